// ==== include/hop_params.svh ====
// register offsets, field positions and reset values of the hop override block
`ifndef HOP_PARAMS_SVH
`define HOP_PARAMS_SVH

`define ADDR_MAIN 7'h00
`define ADDR_RESET 7'h02
`define ADDR_SET_FIRST_2 7'h04
`define ADDR_SET_FIRST_1 7'h05
`define ADDR_SET_FIRST_0 7'h06
`define ADDR_SET_SECOND_2 7'h08
`define ADDR_SET_SECOND_1 7'h09
`define ADDR_SET_SECOND_0 7'h0A
`define ADDR_PUMP_OVR 7'h21
`define ADDR_ARRAY_OVR 7'h22
`define ADDR_BIAS_OVR 7'h23
`define ADDR_PUMP_RES 7'h45
`define ADDR_ARRAY_RES 7'h46
`define ADDR_BIAS_RES 7'h47

`define MAIN_SEL_BIT 6
`define ARRAY_FORCE_BIT 5
`define PUMP_FORCE_BIT 6
`define BIAS_FORCE_BIT 6

`define MAIN_RESET 8'h80
`define SET_RESET 8'h00
`define PUMP_OVR_RESET 8'h00
`define ARRAY_OVR_RESET 8'h00
`define BIAS_OVR_RESET 8'h00

`endif

// ==== include/hop_pkg.sv ====
// types of the hop override block
package hop_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [23:0] word_t;

   typedef struct packed {
      logic [3:0] pump;
      logic [4:0] array;
      logic [5:0] bias;
   } cal_s;

   typedef struct packed {
      byte_t main;
      word_t set_first;
      word_t set_second;
      byte_t pump_ovr;
      byte_t array_ovr;
      byte_t bias_ovr;
      byte_t rdata;
      word_t active_word;
      cal_s applied;
   } hop_state_s;
endpackage

// ==== rtl/hop_channel_calibration_override.sv ====
// hop channel select, calibration result read-back and override control
`timescale 1ns/1ps
`include "hop_params.svh"

// Function
// - two channel word sets are held and the idle one may be written while the other drives.
// - bit 6 of the main control register picks the active channel word set.
// - calibration results read back as pump [3:0], array [4:0] and bias [5:0] status bytes.
// - writable override bytes hold forced values; the array override byte holds the array and pump force enables, the bias byte the bias one.
// - every configuration register is written over the config port; override bytes keep only bits 3:0 (pump) or 6:0 (array, bias), the rest read 0.
// - a commanded reset returns every register, overrides included, to its default.
module hop_channel_calibration_override
   import hop_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [6:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire cal_s found_in,
   output logic [7:0] rdata_out,
   output logic [23:0] active_word_out,
   output cal_s applied_out
);

   hop_state_s state_reg;
   hop_state_s state_next;
   logic soft_rst;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // a write of 1 to the reset byte acts as the commanded reset
   assign soft_rst = wr_en_in && (addr_in == `ADDR_RESET) && wdata_in[0];

   always_comb
   begin
      state_next = state_reg;
      if (wr_en_in)
      begin
         // each word set is three bytes, most significant byte at the lowest offset
         if (addr_in >= `ADDR_SET_FIRST_2 && addr_in <= `ADDR_SET_FIRST_0)
         begin
            unique case (addr_in)
               `ADDR_SET_FIRST_2: state_next.set_first[23:16] = wdata_in;
               `ADDR_SET_FIRST_1: state_next.set_first[15:8] = wdata_in;
               default: state_next.set_first[7:0] = wdata_in;
            endcase
         end
         if (addr_in >= `ADDR_SET_SECOND_2 && addr_in <= `ADDR_SET_SECOND_0)
         begin
            unique case (addr_in)
               `ADDR_SET_SECOND_2: state_next.set_second[23:16] = wdata_in;
               `ADDR_SET_SECOND_1: state_next.set_second[15:8] = wdata_in;
               default: state_next.set_second[7:0] = wdata_in;
            endcase
         end
         if (addr_in == `ADDR_MAIN)
            state_next.main = wdata_in;
         if (addr_in == `ADDR_PUMP_OVR)
            state_next.pump_ovr = {4'h0, wdata_in[3:0]};
         if (addr_in == `ADDR_ARRAY_OVR)
            state_next.array_ovr = {1'b0, wdata_in[6:0]};
         if (addr_in == `ADDR_BIAS_OVR)
            state_next.bias_ovr = {1'b0, wdata_in[6:0]};
      end

      // read data, status bytes show live calibration results
      state_next.rdata = 8'h00;
      if (rd_en_in)
      begin
         unique case (addr_in)
            `ADDR_MAIN: state_next.rdata = state_reg.main;
            `ADDR_SET_FIRST_2: state_next.rdata = state_reg.set_first[23:16];
            `ADDR_SET_FIRST_1: state_next.rdata = state_reg.set_first[15:8];
            `ADDR_SET_FIRST_0: state_next.rdata = state_reg.set_first[7:0];
            `ADDR_SET_SECOND_2: state_next.rdata = state_reg.set_second[23:16];
            `ADDR_SET_SECOND_1: state_next.rdata = state_reg.set_second[15:8];
            `ADDR_SET_SECOND_0: state_next.rdata = state_reg.set_second[7:0];
            `ADDR_PUMP_OVR: state_next.rdata = state_reg.pump_ovr;
            `ADDR_ARRAY_OVR: state_next.rdata = state_reg.array_ovr;
            `ADDR_BIAS_OVR: state_next.rdata = state_reg.bias_ovr;
            `ADDR_PUMP_RES: state_next.rdata = {4'h0, found_in.pump};
            `ADDR_ARRAY_RES: state_next.rdata = {3'h0, found_in.array};
            `ADDR_BIAS_RES: state_next.rdata = {2'h0, found_in.bias};
            default: state_next.rdata = 8'h00;
         endcase
      end

      // outputs follow the registered settings one cycle later
      state_next.active_word = state_reg.main[`MAIN_SEL_BIT] ?
         state_reg.set_second : state_reg.set_first;
      state_next.applied.pump = state_reg.array_ovr[`PUMP_FORCE_BIT] ?
         state_reg.pump_ovr[3:0] : found_in.pump;
      state_next.applied.array = state_reg.array_ovr[`ARRAY_FORCE_BIT] ?
         state_reg.array_ovr[4:0] : found_in.array;
      state_next.applied.bias = state_reg.bias_ovr[`BIAS_FORCE_BIT] ?
         state_reg.bias_ovr[5:0] : found_in.bias;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in || soft_rst)
      begin
         state_reg.main <= `MAIN_RESET;
         state_reg.set_first <= {3{`SET_RESET}};
         state_reg.set_second <= {3{`SET_RESET}};
         state_reg.pump_ovr <= `PUMP_OVR_RESET;
         state_reg.array_ovr <= `ARRAY_OVR_RESET;
         state_reg.bias_ovr <= `BIAS_OVR_RESET;
         state_reg.rdata <= 8'h00;
         state_reg.active_word <= 24'h000000;
         state_reg.applied <= '0;
      end
      else
         state_reg <= state_next;
   end

   assign rdata_out = state_reg.rdata;
   assign active_word_out = state_reg.active_word;
   assign applied_out = state_reg.applied;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_idle_set_write: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (state_reg.main[`MAIN_SEL_BIT] && wr_en_in && !soft_rst
      && addr_in >= `ADDR_SET_FIRST_2 && addr_in <= `ADDR_SET_FIRST_0)
      ##1 (state_reg.main[`MAIN_SEL_BIT] && !soft_rst) |=> $stable(active_word_out))
      else $error("idle set write disturbed active channel");
   a_first_set_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_SET_FIRST_0) |=>
      state_reg.set_first[7:0] == $past(wdata_in))
      else $error("first set low byte not stored");
   a_second_set_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_SET_SECOND_2) |=>
      state_reg.set_second[23:16] == $past(wdata_in))
      else $error("second set high byte not stored");
   a_main_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_MAIN) |=>
      state_reg.main == $past(wdata_in))
      else $error("main control byte not stored");
   a_select_follows: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      !soft_rst |=> active_word_out == ($past(state_reg.main[`MAIN_SEL_BIT]) ?
      $past(state_reg.set_second) : $past(state_reg.set_first)))
      else $error("active channel does not follow select bit");

   a_pump_result: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (rd_en_in && addr_in == `ADDR_PUMP_RES && !soft_rst) |=>
      rdata_out == {4'h0, $past(found_in.pump)})
      else $error("pump result read wrong");
   a_array_result: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (rd_en_in && addr_in == `ADDR_ARRAY_RES && !soft_rst) |=>
      rdata_out == {3'h0, $past(found_in.array)})
      else $error("array result read wrong");
   a_bias_result: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (rd_en_in && addr_in == `ADDR_BIAS_RES && !soft_rst) |=>
      rdata_out == {2'h0, $past(found_in.bias)})
      else $error("bias result read wrong");

   a_pump_override_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_PUMP_OVR) |=>
      state_reg.pump_ovr == {4'h0, $past(wdata_in[3:0])})
      else $error("pump override not stored");
   a_array_override_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_ARRAY_OVR) |=>
      state_reg.array_ovr == {1'b0, $past(wdata_in[6:0])})
      else $error("array override not stored");
   a_bias_override_store: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (wr_en_in && addr_in == `ADDR_BIAS_OVR) |=>
      state_reg.bias_ovr == {1'b0, $past(wdata_in[6:0])})
      else $error("bias override not stored");

   a_pump_forced: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (state_reg.array_ovr[`PUMP_FORCE_BIT] && !soft_rst) |=>
      applied_out.pump == $past(state_reg.pump_ovr[3:0]))
      else $error("pump force not applied");
   a_array_forced: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (state_reg.array_ovr[`ARRAY_FORCE_BIT] && !soft_rst) |=>
      applied_out.array == $past(state_reg.array_ovr[4:0]))
      else $error("array force not applied");
   a_bias_forced: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (state_reg.bias_ovr[`BIAS_FORCE_BIT] && !soft_rst) |=>
      applied_out.bias == $past(state_reg.bias_ovr[5:0]))
      else $error("bias force not applied");
   a_pump_found: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!state_reg.array_ovr[`PUMP_FORCE_BIT] && !soft_rst) |=>
      applied_out.pump == $past(found_in.pump))
      else $error("pump result not applied");
   a_array_found: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!state_reg.array_ovr[`ARRAY_FORCE_BIT] && !soft_rst) |=>
      applied_out.array == $past(found_in.array))
      else $error("array result not applied");
   a_bias_found: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      (!state_reg.bias_ovr[`BIAS_FORCE_BIT] && !soft_rst) |=>
      applied_out.bias == $past(found_in.bias))
      else $error("bias result not applied");

   a_soft_reset: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in)
      soft_rst |=> (state_reg.main == `MAIN_RESET && state_reg.array_ovr == `ARRAY_OVR_RESET
      && state_reg.bias_ovr == `BIAS_OVR_RESET && state_reg.pump_ovr == `PUMP_OVR_RESET
      && state_reg.set_first == {3{`SET_RESET}} && state_reg.set_second == {3{`SET_RESET}}))
      else $error("commanded reset left a register set");

endmodule // hop_channel_calibration_override

// ==== verification/hop_host_model.sv ====
// host model: byte writes and reads on the configuration port
`timescale 1ns/1ps
`include "hop_params.svh"
module hop_host_model
(
   input wire logic clk_in,
   input wire logic [7:0] rdata_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [6:0] addr_out,
   output logic [7:0] wdata_out
);
   // port outputs start idle: no write, no read, address 7F, data 00
   initial
   begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 7'h7F;
      wdata_out = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_in);
      wr_en_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge clk_in);
      wr_en_out = 1'b0;
      // released data must not look like a held value
      wdata_out = ~d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_in);
      rd_en_out = 1'b1;
      addr_out = a;
      @(negedge clk_in);
      rd_en_out = 1'b0;
      d = rdata_in;
   endtask
   // select first, stored calibration after
   task automatic hop(input logic [7:0] m, input logic [7:0] p, input logic [7:0] ar,
                      input logic [7:0] b);
      wr(`ADDR_MAIN, m);
      wr(`ADDR_PUMP_OVR, p);
      wr(`ADDR_ARRAY_OVR, ar);
      wr(`ADDR_BIAS_OVR, b);
   endtask
   task automatic clear_forces(input logic [7:0] ar, input logic [7:0] b);
      wr(`ADDR_ARRAY_OVR, ar & 8'h1F);
      wr(`ADDR_BIAS_OVR, b & 8'h3F);
   endtask
endmodule // hop_host_model

// ==== verification/tb.sv ====
// self-checking testbench of the hop override block
`timescale 1ns/1ps
module tb;
   import hop_pkg::*;
   logic core_clk_in;
   logic sys_rst_in;
   logic wr_en;
   logic rd_en;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   word_t act;
   cal_s found;
   cal_s applied;
   int errors;
   int n_tests;
   initial
   begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end
   hop_channel_calibration_override u_hop_channel_calibration_override (
      .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wdata_in(wdata), .found_in(found), .rdata_out(rdata),
      .active_word_out(act), .applied_out(applied));
   hop_host_model u_hop_host_model (.clk_in(core_clk_in), .rdata_in(rdata), .wr_en_out(wr_en),
      .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
   // ----------------------------------------
   // compares and helpers
   // ----------------------------------------
   task automatic chk_w(input word_t got, input word_t exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_c(input cal_s got, input cal_s exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL t=%0t applied %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [6:0] a, input byte_t exp);
      byte_t d;
      u_hop_host_model.rd(a, d);
      chk_w({16'h0000, d}, {16'h0000, exp});
   endtask
   // outputs follow a write two edges later
   task automatic settle;
      repeat (2) @(negedge core_clk_in);
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_defaults;
      rdc(7'h00, 8'h80);
      rdc(7'h22, 8'h00);
      rdc(7'h03, 8'h00);
      $display("test defaults done");
   endtask
   task automatic test_channel_sets;
      u_hop_host_model.wr(7'h04, 8'h12);
      u_hop_host_model.wr(7'h05, 8'h34);
      u_hop_host_model.wr(7'h06, 8'h56);
      u_hop_host_model.wr(7'h08, 8'hAB);
      u_hop_host_model.wr(7'h09, 8'hCD);
      u_hop_host_model.wr(7'h0A, 8'hEF);
      settle;
      chk_w(act, 24'h123456);
      rdc(7'h05, 8'h34);
      rdc(7'h09, 8'hCD);
      u_hop_host_model.wr(7'h00, 8'hC0);
      u_hop_host_model.wr(7'h04, 8'h99);
      settle;
      chk_w(act, 24'hABCDEF);
      u_hop_host_model.wr(7'h00, 8'h80);
      settle;
      chk_w(act, 24'h993456);
      $display("test channel sets done");
   endtask
   task automatic test_results;
      rdc(7'h45, 8'h0A);
      rdc(7'h46, 8'h15);
      rdc(7'h47, 8'h2A);
      chk_c(applied, {4'hA, 5'h15, 6'h2A});
      $display("test results done");
   endtask
   task automatic test_overrides;
      u_hop_host_model.hop(8'hC0, 8'hF5, 8'h4C, 8'h11);
      settle;
      chk_c(applied, {4'h5, 5'h15, 6'h2A});
      u_hop_host_model.hop(8'hC0, 8'h05, 8'h6C, 8'h51);
      settle;
      chk_c(applied, {4'h5, 5'h0C, 6'h11});
      rdc(7'h21, 8'h05);
      rdc(7'h22, 8'h6C);
      rdc(7'h23, 8'h51);
      u_hop_host_model.clear_forces(8'h6C, 8'h51);
      found = {4'h3, 5'h0A, 6'h15};
      settle;
      chk_c(applied, {4'h3, 5'h0A, 6'h15});
      $display("test overrides done");
   endtask
   task automatic test_commanded_reset;
      u_hop_host_model.wr(7'h22, 8'h60);
      u_hop_host_model.wr(7'h02, 8'h01);
      settle;
      rdc(7'h00, 8'h80);
      rdc(7'h22, 8'h00);
      chk_w(act, 24'h000000);
      chk_c(applied, {4'h3, 5'h0A, 6'h15});
      $display("test commanded reset done");
   endtask
   initial
   begin
      errors = 0;
      n_tests = 0;
      sys_rst_in = 1'b1;
      found = {4'hA, 5'h15, 6'h2A};
      repeat (8) @(negedge core_clk_in);
      sys_rst_in = 1'b0;
      test_defaults;
      test_channel_sets;
      test_results;
      test_overrides;
      test_commanded_reset;
      wrap_up;
   end
   // a full run needs well under 400 cycles
   initial
   begin
      #20000;
      errors++;
      $display("FAIL t=%0t watchdog expired", $time);
      wrap_up;
   end
endmodule // tb
